// ===== dv/accumulator_extension_limiter_tb.sv
// self-checking bench for the accumulator limiter: commands via the core model,
// status, mask and accumulator views via avalon-mm reads and writes
`timescale 1ns/1ps
module accumulator_extension_limiter_tb;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req = 1'b0;
  ael_pkg::ael_cmd_s rq_cmd = '0;
  logic cmd_valid;
  ael_pkg::ael_cmd_s cmd_w;
  ael_pkg::ael_rsp_s rsp;
  logic irq;
  logic [4:0] adr = 5'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_rq;
  logic [31:0] v;
  int n_fail = 0;
  int tests_run = 0;
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  ael_core_model core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req), .req_cmd_i(rq_cmd),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd_w));
  ael_limiter DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd_w),
    .rsp_o(rsp), .irq_o(irq), .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_rq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // request stands until waitrequest is seen low at a rising edge; read data is taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    int n;
    n = 0;
    w = 1'b1;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= d;
    rd_en <= ~wr;
    wr_en <= wr;
    do begin
      @(posedge clk_sys_i);
      w = wait_rq;
      n++;
    end while (w !== 1'b0 && n < 50);
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (w !== 1'b0) begin
      n_fail++;
      final_report();
    end
  endtask : bus
  task automatic rdb(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    bus(1'b0, a, 32'h0, v);
    chk(v & m, e);
  endtask : rdb
  task automatic wrb(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask : wrb
  task automatic cmd(input ael_pkg::ael_op_e op, input ael_pkg::ael_sel_e s, input ael_pkg::ael_sel_e d,
    input logic [15:0] dat, input logic [31:0] add = 32'h0);
    @(posedge clk_sys_i);
    req <= 1'b1;
    rq_cmd <= '{op: op, src: s, dst: d, data: dat, addend: add};
    @(posedge clk_sys_i);
    req <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : cmd
  task automatic rdc(input ael_pkg::ael_sel_e s, input logic [15:0] e);
    cmd(ael_pkg::OP_READ, s, s, 16'h0);
    chk({rsp.valid, rsp.data}, {1'b1, e});
  endtask : rdc
  task automatic t_reset;
    rdb(5'h00, 32'h0);
    wrb(5'h08, 32'h1234_5678);
    rdb(5'h08, 32'h0);
    rdb(5'h1c, 32'h0);
    wrb(5'h04, 32'h7);
    rdb(5'h04, 32'h7);
  endtask : t_reset
  task automatic t_whole;
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_B, 16'ha987);
    rdb(5'h10, 32'ha987_0000);
    rdb(5'h14, 32'hf, 32'hf);
    rdc(ael_pkg::SEL_B_EXT, 16'hffff);
    rdc(ael_pkg::SEL_B, 16'ha987);
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_B_LO, 16'h1234);
    rdb(5'h10, 32'ha987_1234);
    rdb(5'h00, 32'h0);
  endtask : t_whole
  task automatic t_accum;
    wrb(5'h04, 32'h4);
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_A, 16'h7fff);
    cmd(ael_pkg::OP_ACCUM, ael_pkg::SEL_X0, ael_pkg::SEL_A, 16'h0, 32'h0001_0000);
    rdb(5'h00, 32'h1);
    chk(irq, 1'b0);
    rdc(ael_pkg::SEL_A, 16'h7fff);
    chk(irq, 1'b1);
    cmd(ael_pkg::OP_XFER, ael_pkg::SEL_A, ael_pkg::SEL_X0, 16'h0);
    rdb(5'h18, 32'h0000_7fff);
    rdb(5'h08, 32'h8000_0000);
    rdc(ael_pkg::SEL_A_UP, 16'h8000);
    rdb(5'h00, 32'h4);
    @(negedge clk_sys_i);
    chk(irq, 1'b0);
    wrb(5'h04, 32'h0);
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_B, 16'h8000);
    cmd(ael_pkg::OP_ACCUM, ael_pkg::SEL_X0, ael_pkg::SEL_B, 16'h0, 32'hffff_0000);
    rdc(ael_pkg::SEL_B, 16'h8000);
    rdc(ael_pkg::SEL_B_UP, 16'h7fff);
    chk(irq, 1'b0);
    rdb(5'h00, 32'h5);
  endtask : t_accum
  task automatic t_ovf;
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_A_EXT, 16'h0007);
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_A_UP, 16'hffff);
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_A_LO, 16'hffff);
    rdb(5'h0c, 32'h7, 32'hf);
    rdb(5'h08, 32'hffff_ffff);
    cmd(ael_pkg::OP_ACCUM, ael_pkg::SEL_X0, ael_pkg::SEL_A, 16'h0, 32'h0000_0001);
    rdb(5'h00, 32'h3);
  endtask : t_ovf
  task automatic t_xfer;
    cmd(ael_pkg::OP_XFER, ael_pkg::SEL_A_UP, ael_pkg::SEL_B, 16'h0);
    rdb(5'h10, 32'h0);
    rdb(5'h14, 32'h0, 32'hf);
    rdb(5'h00, 32'h0);
    cmd(ael_pkg::OP_XFER, ael_pkg::SEL_A, ael_pkg::SEL_A, 16'h0);
    rdb(5'h08, 32'h8000_0000);
    rdb(5'h0c, 32'hf, 32'hf);
    rdb(5'h00, 32'h4);
  endtask : t_xfer
  task automatic t_bits;
    cmd(ael_pkg::OP_WRITE, ael_pkg::SEL_X0, ael_pkg::SEL_A_EXT, 16'h0000);
    cmd(ael_pkg::OP_BF_TST, ael_pkg::SEL_A, ael_pkg::SEL_A, 16'h7fff);
    chk({rsp.valid, rsp.bit_true}, 2'b11);
    cmd(ael_pkg::OP_BR_SET, ael_pkg::SEL_A, ael_pkg::SEL_A, 16'h8000);
    chk({rsp.valid, rsp.bit_true}, 2'b10);
    rdb(5'h08, 32'h8000_0000);
    cmd(ael_pkg::OP_BF_CLR, ael_pkg::SEL_A, ael_pkg::SEL_A, 16'h000f);
    rdb(5'h08, 32'h7ff0_0000);
    cmd(ael_pkg::OP_BF_SET, ael_pkg::SEL_A_UP, ael_pkg::SEL_A_UP, 16'h800f);
    rdc(ael_pkg::SEL_A_UP, 16'hffff);
    cmd(ael_pkg::OP_BF_CHG, ael_pkg::SEL_A_LO, ael_pkg::SEL_A_LO, 16'h00ff);
    rdb(5'h08, 32'hffff_00ff);
    rdb(5'h0c, 32'h0, 32'hf);
  endtask : t_bits
  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset();
    t_whole();
    t_accum();
    t_ovf();
    t_xfer();
    t_bits();
    final_report();
  end
endmodule : accumulator_extension_limiter_tb

// ===== dv/ael_core_model.sv
// core-side command source feeding the limiter's command port
// assumes the bench raises req_i for one cycle per command, on the rising edge
`timescale 1ns/1ps
module ael_core_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire ael_pkg::ael_cmd_s req_cmd_i,
  output logic cmd_valid_o,
  output ael_pkg::ael_cmd_s cmd_o
);
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
    end else begin
      cmd_valid_o <= req_i;
      // idle bus inverts its own value every cycle, alternating between the last command and its inverse
      cmd_o <= req_i ? req_cmd_i : ael_pkg::ael_cmd_s'(~cmd_o);
    end
  end
endmodule : ael_core_model

// ===== hdl/ael_limiter.sv
// accumulator pair with extension detection, data limiter and status flags
// assumes the core issues one command per cycle on cmd_valid_i and reads the
// answer one cycle later; software reaches status over avalon-mm
// Function
// RQ1: accumulation crossing bit 31 sets the extension-in-use flag.
// RQ2: sign lost beyond the 4-bit extension sets the overflow flag.
// RQ3: extension-in-use decides saturation of whole-accumulator reads and transfers.
// RQ4: saturation changes only the transferred value unless source is destination.
// RQ5: saturated value is 7fff or 8000 by accumulator sign.
// RQ6: any limited transfer sets the limit flag, which stays latched.
// RQ7: only whole-accumulator sources are limited; portions bypass the limiter.
// RQ8: word written to whole accumulator: upper gets word, lower zero, extension signed.
// RQ9: storing the upper word passes bits unchanged, never saturated.
// RQ10: bit-field ops read through the limiter, modify, write back.
// RQ11: bit tests and branch-on-bit never modify any accumulator portion.
// RQ12: upper word moved to whole accumulator sign-extends, zero lower, no limiting.
// RQ13: whole-to-whole move passes the limiter, then sign-extends into destination.
// RQ14: extension read fills bits 15 to 4 with its sign.
// RQ15: a portion write leaves the other two portions unchanged.
// RQ16: saturation sign follows bit 35.
// RQ17: extension-in-use means bits 35 to 31 are not all equal.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ael_limiter (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire ael_pkg::ael_cmd_s cmd_i,
  output ael_pkg::ael_rsp_s rsp_o,
  output logic irq_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  logic [35:0] acc_reg [2];
  logic [35:0] acc_next [2];
  logic [15:0] x0_reg;
  logic [15:0] x0_next;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  ael_pkg::ael_rsp_s rsp_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [2:0] snap_reg;

  // bit 31 and the extension disagree: the upper word alone cannot hold the value
  function automatic logic in_use(input logic [35:0] v);
    return !((&v[35:31]) || !(|v[35:31])); // RQ17
  endfunction : in_use

  function automatic logic [15:0] limit(input logic [35:0] v);
    if (in_use(v)) begin // RQ3
      return v[ael_pkg::SIGN_BIT] ? ael_pkg::FULL_NEG : ael_pkg::FULL_POS; // RQ5 RQ16
    end
    return v[31:16];
  endfunction : limit

  function automatic logic is_whole(input ael_pkg::ael_sel_e s);
    return (s == ael_pkg::SEL_A) || (s == ael_pkg::SEL_B);
  endfunction : is_whole

  function automatic logic acc_idx(input ael_pkg::ael_sel_e s);
    return (s == ael_pkg::SEL_B) || (s == ael_pkg::SEL_B_EXT) || (s == ael_pkg::SEL_B_UP) ||
      (s == ael_pkg::SEL_B_LO);
  endfunction : acc_idx

  function automatic logic [15:0] portion(input logic [35:0] v, input ael_pkg::ael_sel_e s);
    unique case (s)
      ael_pkg::SEL_A, ael_pkg::SEL_B: return limit(v); // RQ7
      ael_pkg::SEL_A_EXT, ael_pkg::SEL_B_EXT: return {{12{v[35]}}, v[35:32]}; // RQ14
      ael_pkg::SEL_A_UP, ael_pkg::SEL_B_UP: return v[31:16]; // RQ9
      default: return v[15:0];
    endcase
  endfunction : portion

  function automatic logic [35:0] put(input logic [35:0] v, input ael_pkg::ael_sel_e s, input logic [15:0] d);
    unique case (s)
      ael_pkg::SEL_A, ael_pkg::SEL_B: return {{4{d[15]}}, d, ael_pkg::LOW_CLEAR}; // RQ8 RQ12
      ael_pkg::SEL_A_EXT, ael_pkg::SEL_B_EXT: return {d[3:0], v[31:0]}; // RQ15
      ael_pkg::SEL_A_UP, ael_pkg::SEL_B_UP: return {v[35:32], d, v[15:0]}; // RQ15
      default: return {v[35:16], d};
    endcase
  endfunction : put

  // read side of every command
  logic [35:0] rd_acc;
  logic [15:0] rd_val;
  logic rd_lim;
  logic [15:0] bf_val;
  logic is_bf;
  logic is_test;
  logic reads_src;
  logic wr_en;
  ael_pkg::ael_sel_e wr_sel;
  logic [15:0] wr_data;
  logic [35:0] add_acc;
  logic [36:0] sum;
  logic acc_en;
  logic ovf_evt;
  logic ext_evt;
  logic lim_evt;

  assign rd_acc = acc_reg[acc_idx(cmd_i.src)];
  assign rd_val = (cmd_i.src == ael_pkg::SEL_X0) ? x0_reg : portion(rd_acc, cmd_i.src);
  assign rd_lim = is_whole(cmd_i.src) && in_use(rd_acc); // RQ3 RQ7
  assign is_bf = (cmd_i.op == ael_pkg::OP_BF_CLR) || (cmd_i.op == ael_pkg::OP_BF_SET) ||
    (cmd_i.op == ael_pkg::OP_BF_CHG);
  assign is_test = (cmd_i.op == ael_pkg::OP_BF_TST) || (cmd_i.op == ael_pkg::OP_BR_SET);
  assign reads_src = (cmd_i.op == ael_pkg::OP_READ) || (cmd_i.op == ael_pkg::OP_XFER) || is_bf || is_test;

  always_comb begin
    unique case (cmd_i.op)
      ael_pkg::OP_BF_CLR: bf_val = rd_val & ~cmd_i.data;
      ael_pkg::OP_BF_SET: bf_val = rd_val | cmd_i.data;
      default: bf_val = rd_val ^ cmd_i.data;
    endcase
  end

  // only writes, moves and bit-field ops use this write path; accumulation has its own, tests have none
  always_comb begin
    wr_en = 1'b0;
    wr_sel = cmd_i.dst;
    wr_data = cmd_i.data;
    if (cmd_valid_i) begin
      if (cmd_i.op == ael_pkg::OP_WRITE) begin
        wr_en = 1'b1;
      end else if (cmd_i.op == ael_pkg::OP_XFER) begin
        wr_en = 1'b1; // RQ4 RQ12 RQ13
        wr_data = rd_val;
      end else if (is_bf) begin
        wr_en = 1'b1; // RQ10
        wr_sel = cmd_i.src;
        wr_data = bf_val;
      end
    end
  end

  // accumulation: 32-bit product-sum sign-extended and added unshifted at bits 31 to 0
  assign add_acc = acc_reg[acc_idx(cmd_i.dst)];
  assign sum = {add_acc[35], add_acc} + {{5{cmd_i.addend[31]}}, cmd_i.addend};
  assign acc_en = cmd_valid_i && (cmd_i.op == ael_pkg::OP_ACCUM) && is_whole(cmd_i.dst);
  assign ext_evt = acc_en && in_use(sum[35:0]); // RQ1
  assign ovf_evt = acc_en && (sum[36] != sum[35]); // RQ2
  assign lim_evt = cmd_valid_i && reads_src && rd_lim; // RQ6

  always_comb begin
    x0_next = x0_reg;
    for (int i = 0; i < 2; i++) begin
      acc_next[i] = acc_reg[i];
      if (acc_en && (acc_idx(cmd_i.dst) == 1'(i))) begin
        acc_next[i] = sum[35:0];
      end else if (wr_en && (wr_sel != ael_pkg::SEL_X0) && (acc_idx(wr_sel) == 1'(i))) begin
        acc_next[i] = put(acc_reg[i], wr_sel, wr_data); // RQ11
      end
    end
    if (wr_en && (wr_sel == ael_pkg::SEL_X0)) begin
      x0_next = wr_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      acc_reg[0] <= ael_pkg::RST_ACC;
      acc_reg[1] <= ael_pkg::RST_ACC;
    end else begin
      acc_reg[0] <= acc_next[0];
      acc_reg[1] <= acc_next[1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      x0_reg <= ael_pkg::RST_WORD;
    end else begin
      x0_reg <= x0_next;
    end
  end

  // answer to the core, one cycle after the command
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= cmd_valid_i && ((cmd_i.op == ael_pkg::OP_READ) || is_test);
      // data and bit_true hold between commands; valid stays high for one cycle only
      if (cmd_valid_i) begin
        rsp_reg.data <= rd_val;
        rsp_reg.bit_true <= is_test && ((rd_val & cmd_i.data) == cmd_i.data);
      end
    end
  end
  assign rsp_o = rsp_reg;

  // register slave: one wait cycle, data captured before the accept edge
  logic bus_req;
  logic bus_take;
  logic st_clr;
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_take = bus_req && ack_reg;
  assign avs_waitrequest_o = bus_req && !ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign st_clr = bus_take && avs_read_i && (avs_address_i == ael_pkg::OFS_STATUS);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data is captured in the wait cycle so that it stands at the accept edge
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0;
      snap_reg <= ael_pkg::RST_STATUS;
    end else begin
      if (bus_req && !ack_reg) begin
        snap_reg <= status_reg;
        unique case (avs_address_i)
          ael_pkg::OFS_STATUS: rdata_reg <= {29'h0, status_reg};
          ael_pkg::OFS_MASK: rdata_reg <= {29'h0, mask_reg};
          ael_pkg::OFS_ACC_A_LO: rdata_reg <= acc_reg[0][31:0];
          ael_pkg::OFS_ACC_A_EXT: rdata_reg <= {28'h0, acc_reg[0][35:32]};
          ael_pkg::OFS_ACC_B_LO: rdata_reg <= acc_reg[1][31:0];
          ael_pkg::OFS_ACC_B_EXT: rdata_reg <= {28'h0, acc_reg[1][35:32]};
          ael_pkg::OFS_X0: rdata_reg <= {16'h0, x0_reg};
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      mask_reg <= ael_pkg::RST_MASK;
    end else if (bus_take && avs_write_i && (avs_address_i == ael_pkg::OFS_MASK)) begin
      mask_reg <= avs_writedata_i[2:0];
    end
  end

  // only bits already shown to software are cleared; a new event wins
  always_comb begin
    status_next = status_reg & ~(st_clr ? snap_reg : 3'h0);
    status_next[ael_pkg::ST_EXT] = status_next[ael_pkg::ST_EXT] | ext_evt; // RQ1
    status_next[ael_pkg::ST_OVF] = status_next[ael_pkg::ST_OVF] | ovf_evt; // RQ2
    status_next[ael_pkg::ST_LIM] = status_next[ael_pkg::ST_LIM] | lim_evt; // RQ6
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      status_reg <= ael_pkg::RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end
  assign irq_o = |(status_reg & mask_reg);

  ext_flag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ1
    ext_evt |=> status_reg[ael_pkg::ST_EXT]) else $error("extension flag not set");
  ovf_flag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ2
    acc_en && (add_acc[35] == cmd_i.addend[31]) && (sum[35] != add_acc[35])
    |=> status_reg[ael_pkg::ST_OVF]) else $error("overflow flag not set");
  sat_value_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ5
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_READ) && is_whole(cmd_i.src) && (rd_acc[35:31] != 5'h0) &&
    (rd_acc[35:31] != 5'h1f) |=> rsp_o.valid && (rsp_o.data == ($past(rd_acc[35]) ? 16'h8000 : 16'h7fff)))
    else $error("wrong saturated value");
  no_sat_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ3
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_READ) && is_whole(cmd_i.src) && !rd_lim
    |=> rsp_o.data == $past(rd_acc[31:16])) else $error("unneeded saturation");
  upper_raw_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ9
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_READ) && (cmd_i.src == ael_pkg::SEL_A_UP)
    |=> rsp_o.data == $past(acc_reg[0][31:16])) else $error("upper word altered");
  src_keep_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_XFER) && (cmd_i.src == ael_pkg::SEL_A) &&
    (cmd_i.dst == ael_pkg::SEL_X0) |=> $stable(acc_reg[0]) && (x0_reg == limit($past(acc_reg[0]))))
    else $error("source accumulator changed");
  whole_write_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ8
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_WRITE) && (cmd_i.dst == ael_pkg::SEL_B)
    |=> acc_reg[1] == {{4{$past(cmd_i.data[15])}}, $past(cmd_i.data), 16'h0000})
    else $error("whole write wrong");
  lim_latch_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ6
    lim_evt ##1 !st_clr |=> status_reg[ael_pkg::ST_LIM]) else $error("limit flag not latched");
  test_keep_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ11
    cmd_valid_i && is_test |=> $stable(acc_reg[0]) && $stable(acc_reg[1])) else $error("test modified accumulator");
  ext_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ14
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_READ) && (cmd_i.src == ael_pkg::SEL_B_EXT)
    |=> (rsp_o.data[3:0] == $past(acc_reg[1][35:32])) && (rsp_o.data[15:4] == {12{rsp_o.data[3]}}))
    else $error("extension read not sign filled");
  portion_keep_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ15
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_WRITE) && (cmd_i.dst == ael_pkg::SEL_A_LO)
    |=> acc_reg[0][35:16] == $past(acc_reg[0][35:16])) else $error("portion write spilled");
  bus_wait_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    bus_req && !ack_reg |=> !(avs_read_i || avs_write_i) || !avs_waitrequest_o) else $error("waitrequest stuck");

  // move, read and bit-field paths, flag set and clear
  lim_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ6
    lim_evt
    |=> status_reg[ael_pkg::ST_LIM])
    else $error("limit flag not set");
  part_bypass_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ7
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_READ) && (cmd_i.src == ael_pkg::SEL_B_UP)
    |=> rsp_o.data == $past(acc_reg[1][31:16]))
    else $error("portion read limited");
  bf_whole_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ10
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_BF_CLR) && (cmd_i.src == ael_pkg::SEL_A)
    |=> (acc_reg[0][15:0] == 16'h0000) && ((acc_reg[0][31:16] & $past(cmd_i.data)) == 16'h0000))
    else $error("bit clear on whole accumulator wrong");
  up_move_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ12
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_XFER) && (cmd_i.src == ael_pkg::SEL_A_UP) &&
    (cmd_i.dst == ael_pkg::SEL_B)
    |=> acc_reg[1] == {{4{$past(acc_reg[0][31])}}, $past(acc_reg[0][31:16]), 16'h0000})
    else $error("upper move not sign extended");
  whole_move_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ13
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_XFER) && (cmd_i.src == ael_pkg::SEL_A) &&
    (cmd_i.dst == ael_pkg::SEL_A)
    |=> (acc_reg[0][15:0] == 16'h0000) && (acc_reg[0][35:32] == {4{acc_reg[0][31]}}))
    else $error("whole move not sign extended");
  sat_sign_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ16
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_XFER) && (cmd_i.dst == ael_pkg::SEL_X0) && rd_lim
    |=> x0_reg == ($past(rd_acc[35]) ? ael_pkg::FULL_NEG : ael_pkg::FULL_POS))
    else $error("saturation sign wrong");
  ext_detect_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ17
    acc_en && (sum[35:32] != {4{sum[31]}})
    |=> status_reg[ael_pkg::ST_EXT])
    else $error("extension in use missed");
  no_lim_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ17
    cmd_valid_i && is_whole(cmd_i.src) && (rd_acc[35:32] == {4{rd_acc[31]}})
    |-> !lim_evt)
    else $error("limited without extension in use");
  clear_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    st_clr && snap_reg[ael_pkg::ST_EXT] && !ext_evt
    |=> !status_reg[ael_pkg::ST_EXT])
    else $error("extension flag not cleared by read");
  same_wb_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_XFER) && (cmd_i.src == ael_pkg::SEL_A) &&
    (cmd_i.dst == ael_pkg::SEL_A) && rd_lim
    |=> acc_reg[0][31:16] == ($past(acc_reg[0][35]) ? ael_pkg::FULL_NEG : ael_pkg::FULL_POS))
    else $error("limited value not written back");
  bf_part_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ7
    cmd_valid_i && (cmd_i.op == ael_pkg::OP_BF_SET) && (cmd_i.src == ael_pkg::SEL_A_UP)
    |=> (acc_reg[0][31:16] == ($past(acc_reg[0][31:16]) | $past(cmd_i.data))) &&
    (acc_reg[0][35:32] == $past(acc_reg[0][35:32])) && (acc_reg[0][15:0] == $past(acc_reg[0][15:0])))
    else $error("bit set on upper word spilled");
endmodule : ael_limiter

// ===== hdl/ael_pkg.sv
// package for the accumulator extension and limiter block
// assumes one core clock; shared by the datapath and its register slave
package ael_pkg;
  localparam int ACC_W = 36;
  localparam int WORD_W = 16;
  localparam int EXT_W = 4;
  localparam int SIGN_BIT = 35;
  localparam int UPPER_MSB = 31;
  localparam int ADDR_W = 5;

  // byte offsets on the register bus
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_ACC_A_LO = 5'h08;
  localparam logic [4:0] OFS_ACC_A_EXT = 5'h0c;
  localparam logic [4:0] OFS_ACC_B_LO = 5'h10;
  localparam logic [4:0] OFS_ACC_B_EXT = 5'h14;
  localparam logic [4:0] OFS_X0 = 5'h18;

  // status bit positions
  localparam int ST_EXT = 0;
  localparam int ST_OVF = 1;
  localparam int ST_LIM = 2;
  localparam int ST_W = 3;

  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [35:0] RST_ACC = 36'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] FULL_POS = 16'h7fff;
  localparam logic [15:0] FULL_NEG = 16'h8000;
  localparam logic [15:0] LOW_CLEAR = 16'h0000;

  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_XFER, OP_ACCUM,
    OP_BF_CLR, OP_BF_SET, OP_BF_CHG, OP_BF_TST, OP_BR_SET
  } ael_op_e;

  typedef enum logic [3:0] {
    SEL_A, SEL_B, SEL_A_EXT, SEL_A_UP, SEL_A_LO,
    SEL_B_EXT, SEL_B_UP, SEL_B_LO, SEL_X0
  } ael_sel_e;

  typedef struct packed {
    ael_op_e op;
    ael_sel_e src;
    ael_sel_e dst;
    logic [15:0] data;
    logic [31:0] addend;
  } ael_cmd_s;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic bit_true;
  } ael_rsp_s;
endpackage : ael_pkg
